/* File: pwmcw_cfg.svh */
/*
  Offsets, field positions, selection codes and reset values of the
  four-channel waveform block. Definitions only; included by bare name.
*/
`ifndef PWMCW_CFG_SVH
`define PWMCW_CFG_SVH

`define PWMCW_AW 10
`define PWMCW_MODE_OFS 10'h000
`define PWMCW_ENA_OFS 10'h004
`define PWMCW_DIS_OFS 10'h008
`define PWMCW_STAT_OFS 10'h00c
`define PWMCW_CH_AREA 2'b10
`define PWMCW_CH_MODE 5'h00
`define PWMCW_CH_DUTY 5'h04
`define PWMCW_CH_PERIOD 5'h08
`define PWMCW_CH_COUNT 5'h0c

`define PWMCW_LIN_DIV_A_LSB 0
`define PWMCW_PRESCALE_SEL_A_LSB 8
`define PWMCW_LIN_DIV_B_LSB 16
`define PWMCW_PRESCALE_SEL_B_LSB 24
`define PWMCW_CHSEL_LSB 0
`define PWMCW_CALIGN_BIT 8
`define PWMCW_START_BIT 9

`define PWMCW_NUM_PRESC 11
`define PWMCW_SEL_LIN_DIV_A 4'hb
`define PWMCW_SEL_LIN_DIV_B 4'hc

`define PWMCW_RST_SEL 4'h0
`define PWMCW_RST_DIV 8'h00
`define PWMCW_RST_PRESC 10'h000
`define PWMCW_RST_DATA 32'h0000_0000

`endif

/* File: pwmcw_load.sv */
/* load on the waveform lines: measures period and high time per line.
   assumes lines sampled on the master clock. */
`timescale 1ns/1ps
`default_nettype none
module pwmcw_load #(parameter int NCH = 4) (
  input wire logic sys_clk, // master clock
  input wire logic rstn, // sync reset, low active
  input wire logic [NCH-1:0] wave, // one line per channel
  output logic [15:0] perLen [NCH], // cycles between rises
  output logic [15:0] hiLen [NCH] // cycles of last high run
);
  logic [NCH-1:0] prev_q;
  logic [15:0] rise_q [NCH];
  logic [15:0] run_q [NCH];
  always_ff @(posedge sys_clk) begin
    for (int c = 0; c < NCH; c++) begin
      if (!rstn) begin
        prev_q[c] <= 1'b0;
        rise_q[c] <= 16'h0;
        run_q[c] <= 16'h0;
        perLen[c] <= 16'h0;
        hiLen[c] <= 16'h0;
      end else begin
        // line levels sampled every clock, nothing edge triggered
        prev_q[c] <= wave[c];
        rise_q[c] <= (wave[c] && !prev_q[c]) ? 16'h1 : rise_q[c] + 16'h1;
        run_q[c] <= wave[c] ? run_q[c] + 16'h1 : 16'h0;
        if (wave[c] && !prev_q[c]) perLen[c] <= rise_q[c];
        if (!wave[c] && prev_q[c]) hiLen[c] <= run_q[c];
      end
    end
  end
endmodule : pwmcw_load
`default_nettype wire

/* File: pwmcw_pkg.sv */
/*
  Types shared by the waveform block.
  Assumes pwmcw_cfg.svh is compiled alongside.
*/
package pwmcw_pkg;

  typedef enum logic {
    DIR_UP = 1'b0,
    DIR_DOWN = 1'b1
  } pwmcw_dir_t;

  typedef logic [3:0] pwmcw_sel_t;
  typedef logic [7:0] pwmcw_div_t;

endpackage : pwmcw_pkg

/* File: pwmcw_top.sv */
/*
  Four-channel pulse width waveform generator: prescaler chain, two
  linear dividers, per-channel counters and comparators, register port.
  Assumes a synchronous master with one-cycle strobes; sys_clk at 125 MHz;
  ce low freezes counting while register writes still land.
*/
// Implementation choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "pwmcw_cfg.svh"

// Behaviour
// - one clock generator and four channels, one waveform line each
// - prescaler offers master clock divided by 1 up to 1024
// - two linear dividers each divide their chosen prescaled clock up to 255
// - reset clears both divide factors and selections, stopping both dividers
// - at reset only the undivided clock ticks; with the block clock gated no prescaler output ticks
// - stopping the block clock keeps all counters and resumes in place
// - configuration writes land even while the block clock is off
// - each channel picks its counting clock by a field resetting to zero
// - each channel has a 16-bit counter stepped by its chosen clock
// - left aligned counter counts up to period minus one then returns to zero
// - center aligned counter counts up to period then down to zero
// - center aligned period lasts twice the left aligned one
// - duty field sets part of period spent at starting level
// - polarity bit picks starting level, low after reset
// - alignment bit picks left or center, left after reset
// - output fixed low for duty equal period pol 0, or zero pol 1
// - output fixed high for duty zero pol 0, or equal period pol 1
// - polarity set while disabled acts at once with ce high, at the first ce cycle when gated; ignored while enabled
// - divide factor 0 stops, 1 passes, 2 to 255 divide
module pwmcw_top
  import pwmcw_pkg::*;
#(
  parameter int NCH = 4,
  parameter int CW = 16
) (
  input wire logic sys_clk, // master clock
  input wire logic rstn, // synchronous reset, low active
  input wire logic ce, // block clock enable
  input wire logic [`PWMCW_AW-1:0] regAddr, // byte address
  input wire logic [31:0] regWdata, // write data
  input wire logic regWr, // write strobe
  input wire logic regRd, // read strobe
  output logic [31:0] regRdata, // read data, cycle after strobe
  output logic [NCH-1:0] wave_out_n // channel waveforms, high active
);

  generate
    if (NCH < 1 || NCH > 8) begin : g_bad_nch
      $error("channel count must lie in 1..8");
    end
    if (CW < 2 || CW > 16) begin : g_bad_cw
      $error("counter width must lie in 2..16");
    end
  endgenerate

  localparam int PW = `PWMCW_NUM_PRESC - 1;

  // ticks of prescaler outputs, dividers selected by a code
  function automatic logic selTick(
    input pwmcw_sel_t sel,
    input logic [PW:0] pt,
    input logic [1:0] dp
  );
    logic t;
    t = 1'b0;
    if (sel < pwmcw_sel_t'(`PWMCW_NUM_PRESC)) begin
      t = pt[sel];
    end else if (sel == `PWMCW_SEL_LIN_DIV_A) begin
      t = dp[0];
    end else if (sel == `PWMCW_SEL_LIN_DIV_B) begin
      t = dp[1];
    end
    return t;
  endfunction : selTick

  // bus registers
  pwmcw_div_t divFac_q [2];
  pwmcw_div_t divFac_d [2];
  pwmcw_sel_t preSel_q [2];
  pwmcw_sel_t preSel_d [2];
  pwmcw_sel_t clkSel_q [NCH];
  pwmcw_sel_t clkSel_d [NCH];
  logic [NCH-1:0] align_q;
  logic [NCH-1:0] align_d;
  logic [NCH-1:0] startLvl_q;
  logic [NCH-1:0] startLvl_d;
  logic [NCH-1:0] chEn_q;
  logic [NCH-1:0] chEn_d;
  logic [CW-1:0] period_q [NCH];
  logic [CW-1:0] period_d [NCH];
  logic [CW-1:0] duty_q [NCH];
  logic [CW-1:0] duty_d [NCH];
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;

  // clock generator state
  logic [PW-1:0] presc_q;
  logic [PW-1:0] presc_d;
  pwmcw_div_t divCnt_q [2];
  pwmcw_div_t divCnt_d [2];
  logic [PW:0] presTick;
  logic [1:0] divPulse;

  // channel state
  logic [CW-1:0] cnt_q [NCH];
  logic [CW-1:0] cnt_d [NCH];
  pwmcw_dir_t dir_q [NCH];
  pwmcw_dir_t dir_d [NCH];
  logic [NCH-1:0] wave_q;
  logic [NCH-1:0] wave_d;

  // address decode
  logic chHit;
  logic [2:0] chIdx;
  logic [4:0] chOfs;
  assign chIdx = regAddr[7:5];
  assign chOfs = regAddr[4:0];
  assign chHit = (regAddr[9:8] == `PWMCW_CH_AREA) &&
    (int'(chIdx) < NCH);

  // prescaler chain and linear dividers
  always_comb begin
    logic run;
    logic [8:0] nxt;
    run = 1'b1;
    nxt = 9'h000;
    for (int k = 0; k <= PW; k++) begin
      presTick[k] = ce & run;
      if (k < PW) begin
        run = run & presc_q[k];
      end
    end
    presc_d = ce ? presc_q + 1'b1 : presc_q;
    for (int i = 0; i < 2; i++) begin
      divCnt_d[i] = divCnt_q[i];
      divPulse[i] = 1'b0;
      nxt = {1'b0, divCnt_q[i]} + 9'h001;
      if (divFac_q[i] == `PWMCW_RST_DIV) begin
        divCnt_d[i] = `PWMCW_RST_DIV;
      end else if (selTick(preSel_q[i], presTick, 2'b00)) begin
        if (nxt >= {1'b0, divFac_q[i]}) begin
          divCnt_d[i] = `PWMCW_RST_DIV;
          divPulse[i] = 1'b1;
        end else begin
          divCnt_d[i] = nxt[7:0];
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      presc_q <= PW'(`PWMCW_RST_PRESC);
      for (int i = 0; i < 2; i++) begin
        divCnt_q[i] <= `PWMCW_RST_DIV;
      end
    end else begin
      presc_q <= presc_d;
      divCnt_q <= divCnt_d;
    end
  end

  // register writes, ungated by ce
  always_comb begin
    logic [NCH-1:0] onehot;
    onehot = '0;
    divFac_d = divFac_q;
    preSel_d = preSel_q;
    clkSel_d = clkSel_q;
    align_d = align_q;
    startLvl_d = startLvl_q;
    chEn_d = chEn_q;
    period_d = period_q;
    duty_d = duty_q;
    if (regWr) begin
      if (regAddr == `PWMCW_MODE_OFS) begin
        divFac_d[0] = regWdata[`PWMCW_LIN_DIV_A_LSB +: 8];
        preSel_d[0] = regWdata[`PWMCW_PRESCALE_SEL_A_LSB +: 4];
        divFac_d[1] = regWdata[`PWMCW_LIN_DIV_B_LSB +: 8];
        preSel_d[1] = regWdata[`PWMCW_PRESCALE_SEL_B_LSB +: 4];
      end else if (regAddr == `PWMCW_ENA_OFS) begin
        chEn_d = chEn_q | regWdata[NCH-1:0];
      end else if (regAddr == `PWMCW_DIS_OFS) begin
        chEn_d = chEn_q & ~regWdata[NCH-1:0];
      end else if (chHit) begin
        for (int c = 0; c < NCH; c++) begin
          onehot[c] = (int'(chIdx) == c);
        end
        for (int c = 0; c < NCH; c++) begin
          if (onehot[c] && chOfs == `PWMCW_CH_MODE) begin
            clkSel_d[c] = regWdata[`PWMCW_CHSEL_LSB +: 4];
            if (!chEn_q[c]) begin
              align_d[c] = regWdata[`PWMCW_CALIGN_BIT];
              startLvl_d[c] = regWdata[`PWMCW_START_BIT];
            end
          end
          if (onehot[c] && chOfs == `PWMCW_CH_DUTY) begin
            duty_d[c] = regWdata[CW-1:0];
          end
          if (onehot[c] && chOfs == `PWMCW_CH_PERIOD) begin
            period_d[c] = regWdata[CW-1:0];
          end
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      for (int i = 0; i < 2; i++) begin
        divFac_q[i] <= `PWMCW_RST_DIV;
        preSel_q[i] <= `PWMCW_RST_SEL;
      end
      for (int c = 0; c < NCH; c++) begin
        clkSel_q[c] <= `PWMCW_RST_SEL;
        period_q[c] <= '0;
        duty_q[c] <= '0;
      end
      align_q <= '0;
      startLvl_q <= '0;
      chEn_q <= '0;
    end else begin
      divFac_q <= divFac_d;
      preSel_q <= preSel_d;
      clkSel_q <= clkSel_d;
      align_q <= align_d;
      startLvl_q <= startLvl_d;
      chEn_q <= chEn_d;
      period_q <= period_d;
      duty_q <= duty_d;
    end
  end

  // channel counters and comparators
  always_comb begin
    logic tick;
    logic [CW:0] up;
    tick = 1'b0;
    up = '0;
    cnt_d = cnt_q;
    dir_d = dir_q;
    for (int c = 0; c < NCH; c++) begin
      tick = selTick(clkSel_q[c], presTick, divPulse);
      up = {1'b0, cnt_q[c]} + {{CW{1'b0}}, 1'b1};
      if (chEn_d[c] && !chEn_q[c]) begin
        cnt_d[c] = '0;
        dir_d[c] = DIR_UP;
      end else if (chEn_q[c] && tick) begin
        if (!align_q[c]) begin
          if (up >= {1'b0, period_q[c]}) begin
            cnt_d[c] = '0;
          end else begin
            cnt_d[c] = up[CW-1:0];
          end
        end else if (dir_q[c] == DIR_UP) begin
          if (up >= {1'b0, period_q[c]}) begin
            cnt_d[c] = period_q[c];
            dir_d[c] = DIR_DOWN;
          end else begin
            cnt_d[c] = up[CW-1:0];
          end
        end else begin
          if (cnt_q[c] <= CW'(1)) begin
            cnt_d[c] = '0;
            dir_d[c] = DIR_UP;
          end else begin
            cnt_d[c] = cnt_q[c] - 1'b1;
          end
        end
      end
      if (!chEn_d[c]) begin
        wave_d[c] = startLvl_d[c];
      end else if (duty_q[c] >= period_q[c]) begin
        wave_d[c] = startLvl_q[c];
      end else if (cnt_d[c] < duty_q[c]) begin
        wave_d[c] = startLvl_q[c];
      end else begin
        wave_d[c] = ~startLvl_q[c];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      for (int c = 0; c < NCH; c++) begin
        cnt_q[c] <= '0;
        dir_q[c] <= DIR_UP;
      end
      wave_q <= '0;
    end else begin
      cnt_q <= cnt_d;
      dir_q <= dir_d;
      if (ce) begin
        wave_q <= wave_d;
      end
    end
  end

  // read data, one cycle after the strobe
  always_comb begin
    rdata_d = `PWMCW_RST_DATA;
    if (regRd) begin
      if (regAddr == `PWMCW_MODE_OFS) begin
        rdata_d[`PWMCW_LIN_DIV_A_LSB +: 8] = divFac_q[0];
        rdata_d[`PWMCW_PRESCALE_SEL_A_LSB +: 4] = preSel_q[0];
        rdata_d[`PWMCW_LIN_DIV_B_LSB +: 8] = divFac_q[1];
        rdata_d[`PWMCW_PRESCALE_SEL_B_LSB +: 4] = preSel_q[1];
      end else if (regAddr == `PWMCW_STAT_OFS) begin
        rdata_d[NCH-1:0] = chEn_q;
      end else if (chHit) begin
        for (int c = 0; c < NCH; c++) begin
          if (int'(chIdx) == c) begin
            case (chOfs)
              `PWMCW_CH_MODE: begin
                rdata_d[`PWMCW_CHSEL_LSB +: 4] = clkSel_q[c];
                rdata_d[`PWMCW_CALIGN_BIT] = align_q[c];
                rdata_d[`PWMCW_START_BIT] = startLvl_q[c];
              end
              `PWMCW_CH_DUTY: rdata_d[CW-1:0] = duty_q[c];
              `PWMCW_CH_PERIOD: rdata_d[CW-1:0] = period_q[c];
              `PWMCW_CH_COUNT: rdata_d[CW-1:0] = cnt_q[c];
              default: rdata_d = `PWMCW_RST_DATA;
            endcase
          end
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      rdata_q <= `PWMCW_RST_DATA;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign regRdata = rdata_q;
  assign wave_out_n = wave_q;

endmodule : pwmcw_top

`default_nettype wire

/* File: pwmcw_top_monitor.sv */
/* port checker for the waveform block, channel 0 shadowed from writes.
   bound to pwmcw_top; assumes the register map of the block. */
`timescale 1ns/1ps
`default_nettype none
module pwmcw_top_monitor
  import pwmcw_pkg::*;
#(parameter int NCH = 4, parameter int CW = 16) (
  input wire logic sys_clk, // master clock
  input wire logic rstn, // sync reset, low active
  input wire logic ce, // block clock enable
  input wire logic [9:0] regAddr, // byte address
  input wire logic [31:0] regWdata, // write data
  input wire logic regWr, // write strobe
  input wire logic regRd, // read strobe
  input wire logic [31:0] regRdata, // read data
  input wire logic [NCH-1:0] wave_out_n // waveforms
);
  logic en_q, pol_q, ali_q, ok;
  logic [3:0] sel_q;
  logic [15:0] per_q, dty_q, age_q, hi_q, lo_q;
  assign ok = en_q && !ali_q && !pol_q && sel_q == 4'h0 && dty_q != 16'h0
    && dty_q < per_q;
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      {en_q, pol_q, ali_q, sel_q} <= '0;
      {per_q, dty_q, age_q, hi_q, lo_q} <= '0;
    end else begin
      if (regWr && regAddr == 10'h004 && regWdata[0]) en_q <= 1'b1;
      if (regWr && regAddr == 10'h008 && regWdata[0]) en_q <= 1'b0;
      if (regWr && regAddr == 10'h200) begin
        sel_q <= regWdata[3:0];
        if (!en_q) {pol_q, ali_q} <= regWdata[9:8];
      end
      if (regWr && regAddr == 10'h204) dty_q <= regWdata[15:0];
      if (regWr && regAddr == 10'h208) per_q <= regWdata[15:0];
      // quiet time since the last write, in enabled cycles
      if (regWr) age_q <= 16'h0;
      else if (ce && age_q != 16'hffff) age_q <= age_q + 16'h1;
      if (ce) hi_q <= wave_out_n[0] ? hi_q + 16'h1 : 16'h0;
      if (ce) lo_q <= wave_out_n[0] ? 16'h0 : lo_q + 16'h1;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  chk_reset_low: assert property ($rose(rstn) |-> wave_out_n == '0)
    else $error("waveforms not low after reset");
  chk_gate_hold: assert property (!ce && !regWr && !$past(regWr)
    |=> $stable(wave_out_n)) else $error("waveform moved with clock off");
  chk_rdata_quiet: assert property (!regRd |=> regRdata == 32'h0)
    else $error("read data outside its cycle");
  chk_left_high: assert property ($fell(wave_out_n[0]) && ok
    && age_q > hi_q + 16'h2 |-> hi_q == per_q - dty_q)
    else $error("high run length wrong");
  chk_left_low: assert property ($rose(wave_out_n[0]) && ok
    && age_q > lo_q + 16'h2 |-> lo_q == dty_q)
    else $error("low run length wrong");
  chk_fixed_low: assert property (dty_q == per_q && !pol_q
    && sel_q == 4'h0 && age_q > 16'h2 |-> !wave_out_n[0])
    else $error("waveform not held low");
  chk_fixed_high: assert property (en_q && dty_q == 16'h0
    && per_q != 16'h0 && !pol_q && sel_q == 4'h0 && age_q > 16'h2
    |-> wave_out_n[0]) else $error("waveform not held high");
  chk_idle_level: assert property (!en_q && age_q > 16'h2
    |-> wave_out_n[0] == pol_q) else $error("idle level wrong");
endmodule : pwmcw_top_monitor
bind pwmcw_top pwmcw_top_monitor #(.NCH(NCH), .CW(CW)) u_mon (
  .sys_clk(sys_clk), .rstn(rstn), .ce(ce), .regAddr(regAddr),
  .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
  .regRdata(regRdata), .wave_out_n(wave_out_n));
`default_nettype wire

/* File: test_pwm_clock_and_channel_waveform.sv */
/* self-checking bench: four channels driving the load model.
   assumes the register map and timing of the block. */
`timescale 1ns/1ps
`default_nettype none
module test_pwm_clock_and_channel_waveform;
  import pwmcw_pkg::*;
  logic sys_clk, rstn, ce, regWr, regRd;
  logic [9:0] regAddr;
  logic [31:0] regWdata, regRdata, rv, r2;
  logic [3:0] wave;
  logic [15:0] perLen [4];
  logic [15:0] hiLen [4];
  int num_errors, comparisons;
  pwmcw_top #(.NCH(4), .CW(16)) dut (.sys_clk(sys_clk), .rstn(rstn),
    .ce(ce), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .wave_out_n(wave));
  pwmcw_load #(.NCH(4)) load (.sys_clk(sys_clk), .rstn(rstn), .wave(wave),
    .perLen(perLen), .hiLen(hiLen));
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  task automatic final_report;
    if (num_errors == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : final_report
  task automatic chk(input string nm, input logic [31:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : cyc
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [9:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1 d = regRdata;
  endtask : rd
  function automatic logic [9:0] cha(input int c, input logic [9:0] o);
    return 10'h200 + 10'(c) * 10'h020 + o;
  endfunction : cha
  task automatic waitPer(input int c, input logic [15:0] e);
    for (int n = 0; n < 400 && perLen[c] !== e; n++) @(posedge sys_clk);
    chk("period", {16'h0, perLen[c]}, {16'h0, e});
    if (perLen[c] !== e) final_report();
  endtask : waitPer
  task automatic waitHi(input int c, input logic [15:0] e);
    for (int n = 0; n < 400 && hiLen[c] !== e; n++) @(posedge sys_clk);
    chk("high time", {16'h0, hiLen[c]}, {16'h0, e});
    if (hiLen[c] !== e) final_report();
  endtask : waitHi
  task automatic t_reset;
    rd(10'h000, rv);
    chk("mode", rv, 32'h0);
    for (int c = 0; c < 4; c++) begin
      rd(cha(c, 10'h0), rv);
      chk("chan mode", rv, 32'h0);
    end
    chk("wave", {28'h0, wave}, 32'h0);
    wr(10'h280, 32'hffff_ffff);
    rd(10'h280, rv);
    chk("fifth channel", rv, 32'h0);
  endtask : t_reset
  task automatic t_waves;
    logic [31:0] md [4] = '{32'h0, 32'h1, 32'h100, 32'hb};
    logic [31:0] dt [4] = '{32'h2, 32'h1, 32'h1, 32'h1};
    logic [31:0] pr [4] = '{32'h5, 32'h5, 32'h4, 32'h3};
    logic [15:0] ex [4] = '{16'd5, 16'd10, 16'd8, 16'd18};
    wr(10'h000, 32'h0000_0103);
    for (int c = 0; c < 4; c++) begin
      wr(cha(c, 10'h0), md[c]);
      wr(cha(c, 10'h4), dt[c]);
      wr(cha(c, 10'h8), pr[c]);
    end
    wr(10'h004, 32'hf);
    for (int c = 0; c < 4; c++) waitPer(c, ex[c]);
    chk("left high", {16'h0, hiLen[0]}, 32'd3);
    chk("center high", {16'h0, hiLen[2]}, 32'd7);
    rd(cha(0, 10'hc), rv);
    chk("count range", {31'h0, rv < 32'd5}, 32'h1);
    rd(10'h00c, rv);
    chk("status", rv, 32'hf);
  endtask : t_waves
  task automatic t_fixed;
    wr(cha(0, 10'h4), 32'h5);
    cyc(10);
    chk("duty full", {31'h0, wave[0]}, 32'h0);
    wr(cha(0, 10'h4), 32'h0);
    cyc(10);
    chk("duty zero", {31'h0, wave[0]}, 32'h1);
  endtask : t_fixed
  task automatic t_polarity;
    wr(10'h008, 32'h1);
    wr(cha(0, 10'h0), 32'h200);
    cyc(2);
    chk("idle level", {31'h0, wave[0]}, 32'h1);
    wr(10'h004, 32'h1);
    cyc(10);
    chk("zero inverted", {31'h0, wave[0]}, 32'h0);
    wr(cha(0, 10'h0), 32'h0);
    rd(cha(0, 10'h0), rv);
    chk("locked mode", rv, 32'h200);
    wr(cha(0, 10'h4), 32'h5);
    cyc(10);
    chk("full inverted", {31'h0, wave[0]}, 32'h1);
  endtask : t_polarity
  task automatic t_gate;
    @(posedge sys_clk);
    ce <= 1'b0;
    rd(cha(1, 10'hc), rv);
    wr(cha(1, 10'h4), 32'h2);
    cyc(8);
    rd(cha(1, 10'hc), r2);
    chk("frozen count", r2, rv);
    rd(cha(1, 10'h4), rv);
    chk("gated write", rv, 32'h2);
    @(posedge sys_clk);
    ce <= 1'b1;
    waitPer(1, 16'd10);
    waitHi(1, 16'd6);
  endtask : t_gate
  task automatic t_lin_div_b;
    wr(10'h000, 32'h0002_0103);
    wr(cha(3, 10'h0), 32'hc);
    waitPer(3, 16'd6);
    rd(10'h000, rv);
    chk("mode b", rv, 32'h0002_0103);
    wr(10'h000, 32'h0000_0103);
    rd(cha(3, 10'hc), rv);
    cyc(8);
    rd(cha(3, 10'hc), r2);
    chk("stopped divider", r2, rv);
  endtask : t_lin_div_b
  initial begin
    repeat (20000) @(posedge sys_clk);
    num_errors++;
    final_report();
  end
  initial begin
    {rstn, ce, regWr, regRd} = 4'b0100;
    regAddr = '0;
    regWdata = '0;
    num_errors = 0;
    comparisons = 0;
    cyc(6);
    rstn <= 1'b1;
    t_reset();
    t_waves();
    t_fixed();
    t_polarity();
    t_gate();
    t_lin_div_b();
    final_report();
  end
endmodule : test_pwm_clock_and_channel_waveform
`default_nettype wire
